// ---- core/xmb_bus.sv ----
// Purpose: external memory bus timing and port pin control
// Assumes: core_clk_in is the oscillator; requests held stable for a machine cycle
// Notes: open-drain enables are active low (low = drive)
`timescale 1ns/1ps
module xmb_bus (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// pins from outside
	input wire logic reset_pin_in,
	input wire logic external_access_select_in,
	input wire logic lock_bit1_in,
	input wire logic [7:0] port_zero_pin_in,
	input wire logic [1:0] p1_pin_in,
	// core requests
	input wire logic [7:0] aux_sfr_in,
	input wire logic [7:0] port_zero_latch_in,
	input wire logic [7:0] port_two_latch_in,
	input wire logic [15:0] fetch_addr_in,
	input wire logic [15:0] data_pointer_in,
	input wire logic [7:0] indirect_addr_in,
	input wire logic [7:0] write_data_in,
	input wire logic data_req_in,
	input wire logic data_write_in,
	input wire logic data_wide_in,
	input wire logic code_move_in,
	input wire logic timer_two_clkout_in,
	input wire logic [7:0] p3_latch_in,
	// pins to outside
	output logic ale_out,
	output logic program_store_strobe_b_out,
	output logic [7:0] port_zero_out,
	output logic [7:0] port_zero_oe_b_out,
	output logic [7:0] port_two_out,
	output logic [7:0] p3_out,
	output logic p1_0_out,
	// to core
	output logic device_reset_out,
	output logic ext_exec_out,
	output logic machine_cycle_start_out,
	output logic [7:0] read_data_out,
	output logic read_valid_out,
	output logic timer_two_count_input_out,
	output logic timer_two_trigger_out
);
	logic [3:0] phase, next_phase;
	logic [4:0] rst_cnt, next_rst_cnt;
	logic dev_rst, next_dev_rst;
	logic ea_lat, next_ea_lat;
	logic was_rst, next_was_rst;
	logic acc_on, next_acc_on;
	xmb_pkg::xmb_acc_type acc_kind, next_acc_kind;
	logic acc_wr, next_acc_wr;
	logic [15:0] acc_addr, next_acc_addr;
	logic [7:0] acc_wdata, next_acc_wdata;
	logic ale, next_ale;
	logic pss_b, next_pss_b;
	logic [7:0] p0, next_p0;
	logic [7:0] p0_oe_b, next_p0_oe_b;
	logic [7:0] p2, next_p2;
	logic [7:0] p3, next_p3;
	logic p10, next_p10;
	logic mc_start, next_mc_start;
	logic [7:0] rdat, next_rdat;
	logic rvalid, next_rvalid;
	logic t2c, next_t2c;
	logic t2x, next_t2x;
	logic ext_exec;
	logic ale_disabled;

	// ----------------------------------------
	// execution mode
	// ----------------------------------------
	// latched level when locked, live pin otherwise
	assign ext_exec = lock_bit1_in ? ~ea_lat : ~external_access_select_in;
	assign ale_disabled = aux_sfr_in[xmb_pkg::xmb_ale_disable_bit] & ~ext_exec;

	// reset pin filter, strap capture, phase counter
	always_comb begin
		next_phase = (phase == xmb_pkg::xmb_phase_last) ? 4'h0 : phase + 4'h1;
		next_rst_cnt = rst_cnt;
		next_dev_rst = dev_rst;
		next_was_rst = dev_rst;
		next_ea_lat = ea_lat;
		if (!reset_pin_in) begin
			next_rst_cnt = 5'h00;
			next_dev_rst = 1'b0;
		end else if (rst_cnt < 5'(xmb_pkg::xmb_reset_cycles - 1)) begin
			next_rst_cnt = rst_cnt + 5'h01;
		end else begin
			next_dev_rst = 1'b1;
		end
		if (dev_rst) begin
			next_phase = 4'h0;
			next_ea_lat = external_access_select_in;
		end
	end

	// ----------------------------------------
	// external data access capture
	// ----------------------------------------
	// an access occupies the machine cycle after it is requested
	always_comb begin
		next_acc_on = acc_on;
		next_acc_kind = acc_kind;
		next_acc_wr = acc_wr;
		next_acc_addr = acc_addr;
		next_acc_wdata = acc_wdata;
		if (phase == xmb_pkg::xmb_phase_last) begin
			next_acc_on = data_req_in & ~dev_rst;
			next_acc_kind = data_wide_in ? xmb_pkg::xmb_acc_data16 : xmb_pkg::xmb_acc_data8;
			next_acc_wr = data_write_in;
			next_acc_addr = data_wide_in ? data_pointer_in : {port_two_latch_in, indirect_addr_in};
			next_acc_wdata = write_data_in;
		end
		if (dev_rst) begin
			next_acc_on = 1'b0;
		end
	end

	// ----------------------------------------
	// strobes and port pins
	// ----------------------------------------
	always_comb begin
		next_ale = ale;
		next_pss_b = pss_b;
		next_p0 = p0;
		next_p0_oe_b = p0_oe_b;
		next_p2 = p2;
		next_p3 = p3_latch_in;
		next_rdat = rdat;
		next_rvalid = 1'b0;
		next_mc_start = (next_phase == 4'h0) & ~dev_rst;
		// address latch strobe at both half-cycle points
		if (next_phase == xmb_pkg::xmb_ale_on_a || next_phase == xmb_pkg::xmb_ale_on_b) begin
			next_ale = 1'b1;
			if (acc_on && next_phase == xmb_pkg::xmb_ale_on_b) begin
				next_ale = 1'b0;
			end else if (ale_disabled && !acc_on && !code_move_in) begin
				next_ale = 1'b0;
			end
		end else if (next_phase == xmb_pkg::xmb_ale_off_a || next_phase == xmb_pkg::xmb_ale_off_b) begin
			next_ale = 1'b0;
		end
		// program store strobe, only in external execution, none during data cycle
		if ((next_phase == xmb_pkg::xmb_pss_on_a || next_phase == xmb_pkg::xmb_pss_on_b) && ext_exec && !acc_on) begin
			next_pss_b = 1'b0;
		end else if (next_phase == xmb_pkg::xmb_pss_off_a || next_phase == xmb_pkg::xmb_pss_off_b || acc_on) begin
			next_pss_b = 1'b1;
		end
		// port zero: address at strobe, then write data, release, or the port zero latch
		if (next_ale) begin
			next_p0 = acc_on ? acc_addr[7:0] : fetch_addr_in[7:0];
			next_p0_oe_b = (ext_exec || acc_on) ? 8'h00 : port_zero_latch_in;
			next_p2 = acc_on ? acc_addr[15:8] : (ext_exec ? fetch_addr_in[15:8] : port_two_latch_in);
		end else if (next_phase == xmb_pkg::xmb_ale_off_a || next_phase == xmb_pkg::xmb_ale_off_b) begin
			if (acc_on && acc_wr) begin
				next_p0 = acc_wdata;
				next_p0_oe_b = 8'h00;
			end else if (acc_on || ext_exec) begin
				next_p0 = 8'hff;
				next_p0_oe_b = 8'hff;
			end else begin
				next_p0 = port_zero_latch_in;
				next_p0_oe_b = port_zero_latch_in;
			end
		end
		// data strobes on P3.6 / P3.7 across the middle of the data cycle
		if (acc_on && phase >= xmb_pkg::xmb_pss_on_a && phase < xmb_pkg::xmb_pss_off_b) begin
			next_p3[6] = ~acc_wr;
			next_p3[7] = acc_wr;
		end
		if (acc_on && !acc_wr && phase == xmb_pkg::xmb_pss_off_b - 4'h1) begin
			next_rdat = port_zero_pin_in;
			next_rvalid = 1'b1;
		end
		if (!pss_b && next_pss_b && !acc_on) begin
			next_rdat = port_zero_pin_in;
			next_rvalid = 1'b1;
		end
		if (dev_rst) begin
			next_ale = 1'b0;
			next_pss_b = 1'b1;
			next_p0_oe_b = 8'hff;
			next_p2 = xmb_pkg::xmb_port_reset;
			next_p3 = xmb_pkg::xmb_port_reset;
		end
	end

	// timer two alternate pins
	always_comb begin
		next_t2c = p1_pin_in[0];
		next_t2x = p1_pin_in[1];
		next_p10 = timer_two_clkout_in;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase <= 4'h0;
			rst_cnt <= 5'h00;
			dev_rst <= 1'b1;
			was_rst <= 1'b1;
			ea_lat <= 1'b1;
			acc_on <= 1'b0;
			acc_kind <= xmb_pkg::xmb_acc_none;
			acc_wr <= 1'b0;
			acc_addr <= 16'h0000;
			acc_wdata <= 8'h00;
			ale <= 1'b0;
			pss_b <= 1'b1;
			p0 <= xmb_pkg::xmb_port_reset;
			p0_oe_b <= 8'hff;
			p2 <= xmb_pkg::xmb_port_reset;
			p3 <= xmb_pkg::xmb_port_reset;
			p10 <= 1'b1;
			mc_start <= 1'b0;
			rdat <= 8'h00;
			rvalid <= 1'b0;
			t2c <= 1'b0;
			t2x <= 1'b0;
		end else begin
			phase <= next_phase;
			rst_cnt <= next_rst_cnt;
			dev_rst <= next_dev_rst;
			was_rst <= next_was_rst;
			ea_lat <= next_ea_lat;
			acc_on <= next_acc_on;
			acc_kind <= next_acc_kind;
			acc_wr <= next_acc_wr;
			acc_addr <= next_acc_addr;
			acc_wdata <= next_acc_wdata;
			ale <= next_ale;
			pss_b <= next_pss_b;
			p0 <= next_p0;
			p0_oe_b <= next_p0_oe_b;
			p2 <= next_p2;
			p3 <= next_p3;
			p10 <= next_p10;
			mc_start <= next_mc_start;
			rdat <= next_rdat;
			rvalid <= next_rvalid;
			t2c <= next_t2c;
			t2x <= next_t2x;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign ale_out = ale;
	assign program_store_strobe_b_out = pss_b;
	assign port_zero_out = p0;
	assign port_zero_oe_b_out = p0_oe_b;
	assign port_two_out = p2;
	assign p3_out = p3;
	assign p1_0_out = p10;
	assign device_reset_out = dev_rst;
	assign ext_exec_out = ea_lat_q_out();
	assign machine_cycle_start_out = mc_start;
	assign read_data_out = rdat;
	assign read_valid_out = rvalid;
	assign timer_two_count_input_out = t2c;
	assign timer_two_trigger_out = t2x;

	function automatic logic ea_lat_q_out();
		return ~ea_lat;
	endfunction
endmodule

// ---- core/xmb_pkg.sv ----
// Purpose: constants for the external memory bus and pin-control block
// Assumes: one oscillator period per core clock cycle, twelve periods per machine cycle
// Notes: pin-level behaviour only; the processor core drives the request inputs
// Notes on behaviour
// - address latch strobe pulses every six oscillator periods in normal operation
// - one address latch strobe pulse is dropped during each external data access
// - with strobe-disable bit set, strobe pulses only during data or code moves
// - strobe-disable bit is ignored while executing from external program memory
// - program store strobe twice per machine cycle in external execution only, two skipped per data access
// - reset pin high for two machine cycles resets the device
// - access select low fetches all code 0000 to ffff externally
// - with lock bit 1, access select is latched at reset and then ignored
// - access select high executes from internal program memory
// - port zero multiplexes low address and data during external accesses
// - port two drives high address for fetches and pointer data accesses
// - port two drives its own latch during register-indirect data accesses
// - P3.6 is the data write strobe, P3.7 the data read strobe
// - writing ones to port zero releases the open-drain pin
// - P1.0 and P1.1 serve as third timer count input and trigger
// - address latch strobe marks valid low address on port zero
package xmb_pkg;
	// timing in oscillator periods
	localparam int unsigned xmb_machine_cycle = 12;
	localparam int unsigned xmb_reset_cycles = 2 * xmb_machine_cycle;
	localparam logic [3:0] xmb_phase_last = 4'hb;
	// strobe phases within a machine cycle (two halves of six periods)
	localparam logic [3:0] xmb_ale_on_a = 4'h0;
	localparam logic [3:0] xmb_ale_off_a = 4'h2;
	localparam logic [3:0] xmb_ale_on_b = 4'h6;
	localparam logic [3:0] xmb_ale_off_b = 4'h8;
	localparam logic [3:0] xmb_pss_on_a = 4'h3;
	localparam logic [3:0] xmb_pss_off_a = 4'h5;
	localparam logic [3:0] xmb_pss_on_b = 4'h9;
	localparam logic [3:0] xmb_pss_off_b = 4'hb;
	// strobe-disable bit location in special function register 8eh
	localparam logic [7:0] xmb_aux_sfr_addr = 8'h8e;
	localparam int unsigned xmb_ale_disable_bit = 0;
	localparam logic [7:0] xmb_port_reset = 8'hff;
	typedef enum logic [1:0] {
		xmb_acc_none,
		xmb_acc_data16,
		xmb_acc_data8
	} xmb_acc_type;
endpackage

// ---- verification/xmb_bus_properties.sv ----
// Purpose: pin timing checks for the external memory bus
// Assumes: sees only the ports of xmb_bus
// Notes: strobes other than ale are low active
`timescale 1ns/1ps
module xmb_properties (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// watched pins
	input wire logic reset_pin_in,
	input wire logic [1:0] p1_pin_in,
	input wire logic ale_out,
	input wire logic program_store_strobe_b_out,
	input wire logic [7:0] port_zero_oe_b_out,
	input wire logic [7:0] p3_out,
	input wire logic device_reset_out,
	input wire logic timer_two_trigger_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in || device_reset_out);
	int hi;
	// run length of the reset pin held high
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hi <= 0;
		end else begin
			hi <= reset_pin_in ? hi + 1 : 0;
		end
	end
	chk_ale_width:
		assert property ($rose(ale_out) |=> ale_out ##1 !ale_out) else $error("ale pulse width");
	chk_ale_gap:
		assert property ($fell(ale_out) |-> !ale_out [*4]) else $error("ale pulse too soon");
	chk_pss_width:
		assert property ($fell(program_store_strobe_b_out) |=> !program_store_strobe_b_out
			##1 program_store_strobe_b_out) else $error("program strobe width");
	chk_pss_after_ale:
		assert property (!program_store_strobe_b_out |-> !ale_out) else $error("strobe overlaps ale");
	chk_read_bus_free:
		assert property (!p3_out[7] |-> program_store_strobe_b_out && port_zero_oe_b_out == 8'hff)
			else $error("bus not free in read");
	chk_write_drive:
		assert property (!p3_out[6] |-> port_zero_oe_b_out == 8'h00 && p3_out[7]) else $error("write not driven");
	chk_trig_copy:
		assert property (1 |=> timer_two_trigger_out == $past(p1_pin_in[1])) else $error("trigger copy");
	chk_rst_filter:
		assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
			$rose(device_reset_out) |-> hi >= 23) else $error("reset taken too early");
	chk_rst_held:
		assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
			reset_pin_in && hi == 30 |-> device_reset_out) else $error("reset not taken");
endmodule
bind xmb_bus xmb_properties chk (.*);

// ---- verification/xmb_ext_mem.sv ----
// Purpose: external memory with address latch on port zero
// Assumes: stored byte is low address xor high address
// Notes: a released bus shows the inverse of its last level
`timescale 1ns/1ps
module xmb_ext_mem (
	// strobes and bus from the device
	input wire logic clk_in,
	input wire logic ale_in,
	input wire logic pss_b_in,
	input wire logic rd_b_in,
	input wire logic [7:0] p0_in,
	input wire logic [7:0] p0_oe_b_in,
	input wire logic [7:0] p2_in,
	// resolved port zero level
	output logic [7:0] pin_out
);
	logic [7:0] lat = 8'h00;
	logic [7:0] last = 8'h00;
	logic hold = 1'b0;
	logic drv;
	assign drv = !pss_b_in || !rd_b_in || hold;
	// latch follows port zero while ale is high, one cycle of data hold
	always @(posedge clk_in) begin
		if (ale_in) lat <= p0_in;
		hold <= !pss_b_in || !rd_b_in;
		last <= pin_out;
	end
	// wire level from both parties
	always_comb begin
		for (int i = 0; i < 8; i++) pin_out[i] = !p0_oe_b_in[i] ? p0_in[i] : drv ? lat[i] ^ p2_in[i] : ~last[i];
	end
endmodule

// ---- verification/xmb_bus_tb.sv ----
// Purpose: self-checking bench for xmb_bus
// Assumes: one core clock per oscillator period
// Notes: a 48 cycle window holds eight ale periods
`timescale 1ns/1ps
module xmb_bus_tb;
	logic core_clk_in = 0, rst_b_in = 0, reset_pin_in = 1, external_access_select_in = 1, lock_bit1_in = 1;
	logic data_req_in = 0, data_write_in = 0, data_wide_in = 0, code_move_in = 0, timer_two_clkout_in = 0;
	logic [1:0] p1_pin_in = 2'h0;
	logic [7:0] port_zero_pin_in, aux_sfr_in = 8'h00, port_zero_latch_in = 8'hff, port_two_latch_in = 8'hff;
	logic [7:0] indirect_addr_in = 8'h5e, write_data_in = 8'h00, p3_latch_in = 8'hff;
	logic [15:0] fetch_addr_in = 16'h4c21, data_pointer_in = 16'h0000;
	logic ale_out, program_store_strobe_b_out, device_reset_out, ext_exec_out, machine_cycle_start_out;
	logic read_valid_out, timer_two_count_input_out, timer_two_trigger_out, p1_0_out;
	logic [7:0] port_zero_out, port_zero_oe_b_out, port_two_out, p3_out, read_data_out, p2r, p2w, p0w, rd;
	int bad_count = 0, compares = 0, na, ns, nm;
	xmb_bus dut (.*);
	xmb_ext_mem mem (.clk_in(core_clk_in), .ale_in(ale_out), .pss_b_in(program_store_strobe_b_out),
		.rd_b_in(p3_out[7]), .p0_in(port_zero_out), .p0_oe_b_in(port_zero_oe_b_out), .p2_in(port_two_out),
		.pin_out(port_zero_pin_in));
	always #2.5 core_clk_in = ~core_clk_in;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// count strobes and capture bus values, optionally with one data request
	task automatic run(input int n, input logic rq);
		logic pa, ps;
		pa = ale_out;
		ps = program_store_strobe_b_out;
		na = 0;
		ns = 0;
		nm = 0;
		{p2r, p2w, p0w, rd} = 32'h0;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk_in);
			if (i == 0) data_req_in <= rq;
			if (i == 12) data_req_in <= 0;
			#1;
			na += (ale_out && !pa);
			ns += (!program_store_strobe_b_out && ps);
			nm += (machine_cycle_start_out === 1);
			if (!p3_out[7]) p2r = port_two_out;
			if (!p3_out[6]) {p2w, p0w} = {port_two_out, port_zero_out};
			if (read_valid_out === 1 && !p3_out[7]) rd = read_data_out;
			pa = ale_out;
			ps = program_store_strobe_b_out;
		end
	endtask
	task automatic wait_rel();
		for (int i = 0; i < 60 && device_reset_out !== 0; i++) @(posedge core_clk_in);
		#1;
		if (device_reset_out !== 0) begin
			bad_count++;
			print_verdict();
		end
	endtask
	task automatic dev_rst(input int n);
		@(posedge core_clk_in);
		reset_pin_in <= 1;
		repeat (n) @(posedge core_clk_in);
		#1;
		chk(device_reset_out, n > 24);
		@(posedge core_clk_in);
		reset_pin_in <= 0;
		wait_rel();
	endtask
	task automatic t_internal();
		run(48, 0);
		chk(na, 8);
		chk(nm, 4);
		chk(ns, 0);
		chk(ext_exec_out, 0);
		aux_sfr_in <= 8'h01;
		run(12, 0);
		run(48, 0);
		chk(na, 0);
		code_move_in <= 1;
		run(12, 0);
		run(48, 0);
		chk(na, 8);
		{code_move_in, aux_sfr_in, port_zero_latch_in, p1_pin_in} <= {1'b0, 8'h00, 8'h0f, 2'h2};
		timer_two_clkout_in <= 1;
		run(12, 0);
		chk(p1_0_out, 1);
		chk(port_zero_oe_b_out, 8'h0f);
		chk(timer_two_trigger_out, 1);
		chk(timer_two_count_input_out, 0);
	endtask
	task automatic t_access(input logic wr, input logic [7:0] n_ale, input logic [7:0] n_pss);
		@(posedge core_clk_in);
		{data_write_in, data_wide_in, data_pointer_in} <= {wr, !wr, 16'h12a5};
		{write_data_in, port_two_latch_in} <= 16'hc33c;
		run(48, 1);
		chk(na, n_ale);
		chk(ns, n_pss);
		if (wr) begin
			chk(p2w, 8'h3c);
			chk(p0w, 8'hc3);
		end else begin
			chk(p2r, 8'h12);
			chk(rd, 8'hb7);
		end
	endtask
	task automatic t_external();
		external_access_select_in <= 0;
		dev_rst(30);
		chk(ext_exec_out, 1);
		external_access_select_in <= 1;
		aux_sfr_in <= 8'h01;
		run(48, 0);
		chk(ext_exec_out, 1);
		chk(na, 8);
		chk(ns, 8);
		t_access(0, 7, 6);
		// unlocked: the live pin (now high) selects internal execution
		lock_bit1_in <= 0;
		run(12, 0);
		run(48, 0);
		chk(ns, 0);
	endtask
	initial begin
		repeat (4) @(posedge core_clk_in);
		rst_b_in <= 1;
		@(posedge core_clk_in);
		reset_pin_in <= 0;
		wait_rel();
		dev_rst(20);
		dev_rst(30);
		t_internal();
		t_access(0, 7, 0);
		t_access(1, 7, 0);
		t_external();
		print_verdict();
	end
endmodule
